// *** epc_pkg.sv ***
/*
 * constants for the external and pin-change interrupt flag block:
 * register indices, field positions, reset values and sense encodings.
 * assumes a classic wishbone slave with 32-bit data, where byte
 * address = 4 * register index, and one 25 MHz system clock.
 */
// What this block does
// - eight external request flags, bit n input n
// - configured edge or change sets external flag
// - flag, enable and global enable request vector
// - flags clear on acknowledge or written one
// - low-level sensing keeps external flag cleared
// - sleep disables buffers of disabled inputs 0-3
// - three group enables gated by global enable
// - inputs 16-23, 8-15, 0-7 form groups 2,1,0
// - change in group sets that group flag
// - group flag and enables request group vector
// - three mask registers, mask and group enable
// - masked-off inputs are ignored for interrupts
// - upper five group bits read zero; reset zero
// - external enable mask gated by global enable
// - sense field: low, change, falling, rising
// - enabled low level requests while input low
// - detection works with pins driven as outputs
package epc_pkg;
    // register indices; byte address is four times the index
    localparam logic [6:0] EPC_IDX_PC_FLAGS   = 7'h1b;
    localparam logic [6:0] EPC_IDX_EXT_FLAGS  = 7'h1c;
    localparam logic [6:0] EPC_IDX_EXT_ENABLE = 7'h1d;
    localparam logic [6:0] EPC_IDX_GRP_ENABLE = 7'h68;
    localparam logic [6:0] EPC_IDX_SENSE_LO   = 7'h69;
    localparam logic [6:0] EPC_IDX_SENSE_HI   = 7'h6a;
    localparam logic [6:0] EPC_IDX_MASK_LOW   = 7'h6b;
    localparam logic [6:0] EPC_IDX_MASK_MID   = 7'h6c;
    localparam logic [6:0] EPC_IDX_MASK_HIGH  = 7'h6d;
    localparam logic [6:0] EPC_IDX_IRQ_STATUS = 7'h70;
    localparam logic [6:0] EPC_IDX_IRQ_CLEAR  = 7'h71;
    localparam logic [6:0] EPC_IDX_IRQ_ENABLE = 7'h72;

    // field layout
    localparam int EPC_EXT_N     = 8;   // dedicated external inputs
    localparam int EPC_GRP_N     = 3;   // pin-change groups
    localparam int EPC_GRP_W     = 8;   // inputs per group
    localparam int EPC_PC_N      = EPC_GRP_N * EPC_GRP_W;
    localparam int EPC_BUF_OFF_N = 4;   // inputs whose buffer sleeps
    localparam int EPC_EVT_N     = EPC_EXT_N + EPC_GRP_N;
    localparam int EPC_SENSE_W   = 2;

    // reset values
    localparam logic [7:0]  EPC_RST_BYTE = 8'h00;
    localparam logic [10:0] EPC_RST_EVT  = 11'h000;
    localparam logic [31:0] EPC_RD_ZERO  = 32'h0000_0000;

    // sense-control encodings
    typedef enum logic [1:0] {
        EPC_SENSE_LOW  = 2'h0,
        EPC_SENSE_ANY  = 2'h1,
        EPC_SENSE_FALL = 2'h2,
        EPC_SENSE_RISE = 2'h3
    } epc_sense_t;
endpackage

// *** epc_irq_flags.sv ***
/*
 * external and pin-change interrupt flag, enable and mask logic with a
 * classic wishbone register slave and a summary interrupt output.
 * assumes pins arrive asynchronously, the core supplies the global
 * interrupt enable and one-cycle vector acknowledge pulses, and that
 * the bus master keeps the classic single-cycle handshake.
 */
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
module epc_irq_flags
    import epc_pkg::*;
(
    input  wire logic                 clk_i,          // 25 MHz system clock
    input  wire logic                 rst_i,          // synchronous, active high
    // wishbone classic slave
    input  wire logic                 cyc_i,
    input  wire logic                 stb_i,
    input  wire logic                 we_i,
    input  wire logic [8:0]           adr_i,
    input  wire logic [3:0]           sel_i,
    input  wire logic [31:0]          dat_i,
    output logic      [31:0]          dat_o,
    output logic                      ack_o,
    // pins and core side
    input  wire logic [EPC_EXT_N-1:0] ext_irq_input_i,
    input  wire logic [EPC_PC_N-1:0]  change_watched_input_i,
    input  wire logic                 global_irq_enable_i,
    input  wire logic                 sleep_i,
    input  wire logic [EPC_EXT_N-1:0] ext_vector_ack_i,
    input  wire logic [EPC_GRP_N-1:0] group_vector_ack_i,
    output logic      [EPC_EXT_N-1:0] ext_vector_req_o,
    output logic      [EPC_GRP_N-1:0] group_vector_req_o,
    output logic                      irq_o
);
    localparam int PIN_N = EPC_EXT_N + EPC_PC_N;

    // registers
    logic [7:0]           ext_request_flags_r;     // external request flags
    logic [7:0]           external_enable_mask_r;  // per-input enables
    logic [EPC_GRP_N-1:0] group_enable_r;          // pin-change group enables
    logic [EPC_GRP_N-1:0] group_flag_r;            // pin-change group flags
    logic [7:0]           sense_lo_r;              // sense fields inputs 3..0
    logic [7:0]           sense_hi_r;              // sense fields inputs 7..4
    logic [7:0]           mask_r [EPC_GRP_N];      // pin-change masks
    logic [EPC_EVT_N-1:0] irq_status_r;            // sticky event status
    logic [EPC_EVT_N-1:0] irq_enable_r;            // event enables
    logic                 ack_r;                   // bus acknowledge
    logic [31:0]          dat_r;                   // read data

    // synchroniser and filter
    logic [PIN_N-1:0]     pin_gated;               // pins after buffer gating
    logic [PIN_N-1:0]     sync1_r;                 // first stage, read by sync2 only
    logic [PIN_N-1:0]     sync2_r;
    logic [PIN_N-1:0]     sync3_r;
    logic [PIN_N-1:0]     stable_r;                // last agreed level
    logic [PIN_N-1:0]     pin_rise;
    logic [PIN_N-1:0]     pin_fall;

    // decode and event terms
    logic [6:0]           reg_idx;
    logic                 bus_req;
    logic                 wr_now;                  // write takes effect this edge
    logic                 wr_lane0;
    logic [15:0]          sense_all;
    logic [EPC_EXT_N-1:0] ext_hit;
    logic [EPC_EXT_N-1:0] ext_is_level;
    logic [EPC_EXT_N-1:0] ext_flag_nxt;
    logic [EPC_GRP_N-1:0] grp_hit;
    logic [EPC_GRP_N-1:0] grp_flag_nxt;
    logic [EPC_EVT_N-1:0] evt_set;
    logic [EPC_EVT_N-1:0] irq_status_nxt;
    logic [EPC_EVT_N-1:0] irq_enable_nxt;          // enable as it stands after this edge
    logic [7:0]           w1c_ext;
    logic [EPC_GRP_N-1:0] w1c_grp;
    logic [EPC_EVT_N-1:0] w1c_evt;

    assign reg_idx   = adr_i[8:2];
    assign bus_req   = cyc_i & stb_i;
    assign wr_now    = bus_req & we_i & ack_r;
    assign wr_lane0  = wr_now & sel_i[0];
    assign sense_all = {sense_hi_r, sense_lo_r};

    // the low four external inputs lose their input buffer in sleep when
    // disabled; a disabled buffer reads low, so a high pin makes a falling
    // change that may set the flag, exactly as the part behaves
    genvar gi;
    generate
        for (gi = 0; gi < EPC_EXT_N; gi++)
        begin : g_ext_buf
            if (gi < EPC_BUF_OFF_N)
            begin : g_sleepy
                assign pin_gated[gi] = ext_irq_input_i[gi]
                                     & ~(sleep_i & ~external_enable_mask_r[gi]);
            end
            else
            begin : g_awake
                assign pin_gated[gi] = ext_irq_input_i[gi];
            end
        end
    endgenerate
    // pins are watched regardless of their direction, so software can
    // drive a pin as output to raise its own interrupt
    assign pin_gated[PIN_N-1:EPC_EXT_N] = change_watched_input_i;

    // three-stage synchroniser; a level is accepted once stage two and
    // stage three agree, which filters a single-sample glitch
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
        end
        else
        begin
            sync1_r <= pin_gated;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // filtered level; change is a comparison of consecutive agreed samples
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            stable_r <= '0;
        else
            stable_r <= (sync2_r == sync3_r) ? sync3_r : stable_r;
    end

    generate
        for (gi = 0; gi < PIN_N; gi++)
        begin : g_edge
            // a change counts only when stages two and three agree
            assign pin_rise[gi] = (sync2_r[gi] == sync3_r[gi])
                                & sync3_r[gi] & ~stable_r[gi];
            assign pin_fall[gi] = (sync2_r[gi] == sync3_r[gi])
                                & ~sync3_r[gi] & stable_r[gi];
        end
    endgenerate

    // per external input: sense decode, flag next value, vector request
    generate
        for (gi = 0; gi < EPC_EXT_N; gi++)
        begin : g_ext
            epc_sense_t sense;
            assign sense = epc_sense_t'(sense_all[gi*EPC_SENSE_W +: EPC_SENSE_W]);
            // a mux rather than a per-bit process, so each bit has one driver
            assign ext_hit[gi] =
                (sense == EPC_SENSE_ANY)  ? (pin_rise[gi] | pin_fall[gi]) :
                (sense == EPC_SENSE_FALL) ? pin_fall[gi] :
                (sense == EPC_SENSE_RISE) ? pin_rise[gi] :
                1'b0;                                  // low level: no edge event
            assign ext_is_level[gi] = (sense == EPC_SENSE_LOW);
            // set wins over clear; level sensing holds the flag at zero
            assign ext_flag_nxt[gi] = ext_is_level[gi] ? 1'b0 :
                (ext_hit[gi] | (ext_request_flags_r[gi]
                 & ~ext_vector_ack_i[gi] & ~w1c_ext[gi]));
            // low level requests for as long as the filtered pin stays low
            assign ext_vector_req_o[gi] = global_irq_enable_i
                & external_enable_mask_r[gi]
                & (ext_is_level[gi] ? ~stable_r[gi]
                                    : ext_request_flags_r[gi]);
        end
    endgenerate

    // per pin-change group: masked change, flag next value, request
    generate
        for (gi = 0; gi < EPC_GRP_N; gi++)
        begin : g_grp
            logic [EPC_GRP_W-1:0] chg;
            // group g owns inputs 8g..8g+7 of the watched bus
            assign chg = pin_rise[EPC_EXT_N + gi*EPC_GRP_W +: EPC_GRP_W]
                       | pin_fall[EPC_EXT_N + gi*EPC_GRP_W +: EPC_GRP_W];
            // a pin counts only if its mask bit and group enable are one
            assign grp_hit[gi] = group_enable_r[gi] & |(chg & mask_r[gi]);
            assign grp_flag_nxt[gi] = grp_hit[gi]
                | (group_flag_r[gi] & ~group_vector_ack_i[gi] & ~w1c_grp[gi]);
            assign group_vector_req_o[gi] = global_irq_enable_i
                & group_enable_r[gi] & group_flag_r[gi];
        end
    endgenerate

    // write-one-to-clear strobes, valid only on the acknowledging edge
    assign w1c_ext = (wr_lane0 && reg_idx == EPC_IDX_EXT_FLAGS) ? dat_i[7:0] : 8'h00;
    assign w1c_grp = (wr_lane0 && reg_idx == EPC_IDX_PC_FLAGS)
                   ? dat_i[EPC_GRP_N-1:0] : 3'h0;
    assign w1c_evt = (wr_now && reg_idx == EPC_IDX_IRQ_CLEAR)
                   ? dat_i[EPC_EVT_N-1:0] : EPC_RST_EVT;

    // flag registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ext_request_flags_r <= EPC_RST_BYTE;
            group_flag_r        <= 3'h0;
        end
        else
        begin
            ext_request_flags_r <= ext_flag_nxt;
            group_flag_r        <= grp_flag_nxt;
        end
    end

    // plain read/write control registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            external_enable_mask_r <= EPC_RST_BYTE;
            group_enable_r         <= 3'h0;
            sense_lo_r             <= EPC_RST_BYTE;
            sense_hi_r             <= EPC_RST_BYTE;
            irq_enable_r           <= EPC_RST_EVT;
            for (int g = 0; g < EPC_GRP_N; g++)
                mask_r[g] <= EPC_RST_BYTE;
        end
        else if (wr_lane0)
        begin
            case (reg_idx)
                EPC_IDX_EXT_ENABLE: external_enable_mask_r <= dat_i[7:0];
                EPC_IDX_GRP_ENABLE: group_enable_r <= dat_i[EPC_GRP_N-1:0];
                EPC_IDX_SENSE_LO:   sense_lo_r <= dat_i[7:0];
                EPC_IDX_SENSE_HI:   sense_hi_r <= dat_i[7:0];
                EPC_IDX_MASK_LOW:   mask_r[0] <= dat_i[7:0];
                EPC_IDX_MASK_MID:   mask_r[1] <= dat_i[7:0];
                EPC_IDX_MASK_HIGH:  mask_r[2] <= dat_i[7:0];
                EPC_IDX_IRQ_ENABLE: irq_enable_r <= dat_i[EPC_EVT_N-1:0];
                default:            ; // read-only, clear-only or unmapped
            endcase
        end
    end

    // sticky event status: flag-setting hits are the events; set beats clear
    assign evt_set        = {grp_hit, ext_hit};
    assign irq_status_nxt = evt_set | (irq_status_r & ~w1c_evt);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_status_r <= EPC_RST_EVT;
        else
            irq_status_r <= irq_status_nxt;
    end

    // the output follows a new enable on the same edge it is written
    assign irq_enable_nxt = (wr_lane0 && reg_idx == EPC_IDX_IRQ_ENABLE)
                          ? dat_i[EPC_EVT_N-1:0] : irq_enable_r;

    // level interrupt while any enabled status bit stands
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(irq_status_nxt & irq_enable_nxt);
    end

    // bus acknowledge: one wait cycle, then a single-cycle ack
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_r <= 1'b0;
        else
            ack_r <= bus_req & ~ack_r;
    end
    assign ack_o = ack_r;

    // read data captured with the ack; reserved and unmapped read zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_r <= EPC_RD_ZERO;
        else if (bus_req & ~ack_r)
        begin
            dat_r <= EPC_RD_ZERO;
            case (reg_idx)
                EPC_IDX_PC_FLAGS:   dat_r[EPC_GRP_N-1:0] <= group_flag_r;
                EPC_IDX_EXT_FLAGS:  dat_r[7:0] <= ext_request_flags_r;
                EPC_IDX_EXT_ENABLE: dat_r[7:0] <= external_enable_mask_r;
                EPC_IDX_GRP_ENABLE: dat_r[EPC_GRP_N-1:0] <= group_enable_r;
                EPC_IDX_SENSE_LO:   dat_r[7:0] <= sense_lo_r;
                EPC_IDX_SENSE_HI:   dat_r[7:0] <= sense_hi_r;
                EPC_IDX_MASK_LOW:   dat_r[7:0] <= mask_r[0];
                EPC_IDX_MASK_MID:   dat_r[7:0] <= mask_r[1];
                EPC_IDX_MASK_HIGH:  dat_r[7:0] <= mask_r[2];
                EPC_IDX_IRQ_STATUS: dat_r[EPC_EVT_N-1:0] <= irq_status_r;
                EPC_IDX_IRQ_ENABLE: dat_r[EPC_EVT_N-1:0] <= irq_enable_r;
                default:            dat_r <= EPC_RD_ZERO;
            endcase
        end
    end
    assign dat_o = dat_r;

    // ------------------------------------------------------------------
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_bus_req;
        bus_req && !ack_r;
    endsequence
    sequence s_ack_once;
        ack_r ##1 !ack_r;
    endsequence

    a_bus_ack_timing: assert property (s_bus_req |=> s_ack_once)
        else $error("ack not given exactly one cycle after request");

    a_ext_edge_set: assert property (ext_hit[3] |=> ext_request_flags_r[3])
        else $error("external edge did not set its flag");

    a_ext_vec_req: assert property (
        (ext_request_flags_r[3] && external_enable_mask_r[3] && global_irq_enable_i
         && sense_all[7:6] != 2'h0) |-> ext_vector_req_o[3])
        else $error("enabled external flag raised no vector request");

    a_ext_ack_clear: assert property (
        (ext_vector_ack_i[3] && !ext_hit[3]) |=> !ext_request_flags_r[3])
        else $error("vector acknowledge did not clear external flag");

    a_grp_ack_clear: assert property (
        (group_vector_ack_i[1] && !grp_hit[1]) |=> !group_flag_r[1])
        else $error("vector acknowledge did not clear group flag");

    a_grp_w1c: assert property (
        (wr_lane0 && reg_idx == EPC_IDX_PC_FLAGS && dat_i[1] && !grp_hit[1])
        |=> !group_flag_r[1])
        else $error("written one did not clear group flag");

    a_level_flag_zero: assert property (
        (sense_lo_r[1:0] == 2'h0) |=> !ext_request_flags_r[0])
        else $error("flag set while input sensed by level");

    a_sleep_buf_off: assert property (
        (sleep_i && !external_enable_mask_r[3]) |-> !pin_gated[3])
        else $error("sleeping disabled input buffer still passes pin");

    a_grp_gate: assert property (
        group_vector_req_o[2] |-> (global_irq_enable_i && group_enable_r[2]
                                   && group_flag_r[2]))
        else $error("group vector requested without flag and enables");

    a_mask_ignore: assert property (
        ((g_grp[1].chg & mask_r[1]) == 8'h00) |-> !grp_hit[1])
        else $error("masked inputs raised a group change");

    a_reserved_zero: assert property (
        (ack_r && !we_i && (reg_idx == EPC_IDX_PC_FLAGS
                            || reg_idx == EPC_IDX_GRP_ENABLE)) |-> dat_o[7:3] == 5'h00)
        else $error("reserved group bits read nonzero");

    a_level_request: assert property (
        (sense_lo_r[1:0] == 2'h0 && external_enable_mask_r[0]
         && global_irq_enable_i && !stable_r[0]) |-> ext_vector_req_o[0])
        else $error("low level did not hold the request");

    a_sync_latency: assert property (
        ($rose(sync2_r[16]) ##1 (sync2_r[16] && sync3_r[16] && !stable_r[16]
         && group_enable_r[1] && mask_r[1][0])) |=> group_flag_r[1])
        else $error("synchronised change did not set group flag");

    a_status_sticky: assert property (
        (irq_status_r[3] && !w1c_evt[3]) |=> irq_status_r[3])
        else $error("status bit dropped without a clear");

    a_irq_level: assert property (
        (|(irq_status_r & irq_enable_r)) |-> irq_o)
        else $error("interrupt output low with enabled status set");

    a_irq_quiet: assert property (
        !(|(irq_status_r & irq_enable_r)) |-> !irq_o)
        else $error("interrupt output high with no enabled status");
endmodule

// *** epc_core_model.sv ***
/*
 * processor core model: acknowledges vector requests after a wait.
 * assumes requests are levels that drop once the flag has cleared.
 */
`timescale 1ns/1ps
module epc_core_model
    import epc_pkg::*;
(
    input  wire logic                 clk_i,     // system clock
    input  wire logic                 rst_i,     // synchronous reset
    input  wire logic                 ack_en_i,  // answer vectors at all
    input  wire logic [3:0]           delay_i,   // cycles a request waits
    input  wire logic [EPC_EXT_N-1:0] ext_req_i, // external vector requests
    input  wire logic [EPC_GRP_N-1:0] grp_req_i, // group vector requests
    output logic      [EPC_EXT_N-1:0] ext_ack_o, // one-cycle entry pulses
    output logic      [EPC_GRP_N-1:0] grp_ack_o
);
    logic [3:0] wait_r; // cycles some request has stood
    logic       fire;   // enter the vector now

    assign fire = ack_en_i && (|{ext_req_i, grp_req_i}) && (wait_r == delay_i);

    // wait counter restarts whenever no request stands
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !ack_en_i || !(|{ext_req_i, grp_req_i}))
            wait_r <= 4'h0;
        else
            wait_r <= wait_r + 4'h1;
    end

    // pulse ack for every request standing when the wait ends
    always_ff @(posedge clk_i)
    begin
        ext_ack_o <= (fire && !rst_i) ? ext_req_i : '0;
        grp_ack_o <= (fire && !rst_i) ? grp_req_i : '0;
    end
endmodule

// *** epc_irq_flags_test.sv ***
/*
 * self-checking bench: wishbone register tasks, pin stimulus, core model.
 * assumes the one-cycle ack of the slave and a 40 ns clock.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin failures++; \
    $display("Error %s exp %h got %h", nm, ex, got); end end
module epc_irq_flags_test
    import epc_pkg::*;
;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
    logic [8:0]  adr_i = '0;
    logic [3:0]  sel_i = '0;
    logic [31:0] dat_i = '0, dat_o, rdv;
    logic [7:0]  ext_in = '0, ext_req, ext_ack;
    logic [23:0] pc_in = '0;
    logic [2:0]  grp_req, grp_ack;
    logic        gie = 0, sleep = 0, irq_o, ack_en = 0;
    int          failures = 0, checked = 0, cyc_n = 0, k;
    logic [6:0]  ri [9] = '{7'h1b, 7'h1c, 7'h1d, 7'h68, 7'h69, 7'h6a, 7'h6b, 7'h6c, 7'h6d};

    always #20 clk_i = ~clk_i;

    epc_irq_flags u_epc_irq_flags (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .ext_irq_input_i(ext_in),
        .change_watched_input_i(pc_in), .global_irq_enable_i(gie), .sleep_i(sleep),
        .ext_vector_ack_i(ext_ack), .group_vector_ack_i(grp_ack),
        .ext_vector_req_o(ext_req), .group_vector_req_o(grp_req), .irq_o(irq_o));

    epc_core_model u_epc_core_model (.clk_i(clk_i), .rst_i(rst_i), .ack_en_i(ack_en),
        .delay_i(4'h3), .ext_req_i(ext_req), .grp_req_i(grp_req),
        .ext_ack_o(ext_ack), .grp_ack_o(grp_ack));

    task automatic print_verdict();
        $display("counts: %0d checked, %0d failures", checked, failures);
        if (failures == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clk_i)
    begin
        cyc_n++;
        if (cyc_n >= 20000)
        begin
            failures++;
            print_verdict();
        end
    end

    // one classic cycle; held until ack is sampled, then released
    task automatic bus(input logic w, input logic [6:0] i, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= {i, 2'b00}; sel_i <= 4'h1; dat_i <= d;
        // only the bench hang guard ends a wait that never sees ack
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rdv = dat_o;
        cyc_i <= 0; stb_i <= 0; we_i <= 0;
    endtask

    task automatic wr(input logic [6:0] i, input logic [31:0] d);
        bus(1'b1, i, d);
    endtask

    task automatic rc(input logic [6:0] i, input logic [31:0] ex, input string nm);
        bus(1'b0, i, 32'h0000_0000);
        `CHK(nm, ex, rdv)
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    initial
    begin
        step(10);
        rst_i <= 0;
        // registers come up zero, unmapped reads zero, spare bits read zero
        foreach (ri[j]) rc(ri[j], 32'h0000_0000, "reset");
        rc(7'h40, 32'h0000_0000, "unmapped");
        wr(EPC_IDX_GRP_ENABLE, 32'h0000_00ff);
        rc(EPC_IDX_GRP_ENABLE, 32'h0000_0007, "grp_en");
        wr(EPC_IDX_PC_FLAGS, 32'h0000_00ff);
        rc(EPC_IDX_PC_FLAGS, 32'h0000_0000, "pc_ro");
        $display("test reset done");
        // inputs 3..0 sense rise, fall, any, low
        wr(EPC_IDX_SENSE_LO, 32'h0000_00e4);
        ext_in <= 8'h0f;
        step(6);
        rc(EPC_IDX_EXT_FLAGS, 32'h0000_000a, "rise_any");
        wr(EPC_IDX_EXT_FLAGS, 32'h0000_0000);
        rc(EPC_IDX_EXT_FLAGS, 32'h0000_000a, "w0_keep");
        wr(EPC_IDX_EXT_FLAGS, 32'h0000_000f);
        rc(EPC_IDX_EXT_FLAGS, 32'h0000_0000, "w1c");
        ext_in <= 8'h00;
        step(6);
        rc(EPC_IDX_EXT_FLAGS, 32'h0000_0006, "fall_any");
        wr(EPC_IDX_EXT_FLAGS, 32'h0000_00ff);
        wr(EPC_IDX_EXT_ENABLE, 32'h0000_0001);
        gie <= 1;
        step(5);
        @(negedge clk_i);
        `CHK("lvl_req", 8'h01, ext_req)
        rc(EPC_IDX_EXT_FLAGS, 32'h0000_0000, "lvl_flag");
        gie <= 0;
        @(negedge clk_i);
        `CHK("gie_off", 8'h00, ext_req)
        $display("test sense done");
        // core enters the vector and the flag clears by itself
        wr(EPC_IDX_EXT_ENABLE, 32'h0000_0008);
        gie <= 1;
        ack_en <= 1;
        ext_in <= 8'h08;
        k = 0;
        while (ext_req[3] !== 1'b1 && k < 20) begin @(negedge clk_i); k++; end
        `CHK("vec_req", 1'b1, ext_req[3])
        step(8);
        rc(EPC_IDX_EXT_FLAGS, 32'h0000_0000, "vec_ack");
        ack_en <= 0;
        $display("test vector done");
        // masked pin ignored, unmasked pin sets its group flag
        wr(EPC_IDX_MASK_MID, 32'h0000_0001);
        pc_in <= 24'h00_0200;
        step(6);
        rc(EPC_IDX_PC_FLAGS, 32'h0000_0000, "masked");
        pc_in <= 24'h00_0300;
        step(6);
        rc(EPC_IDX_PC_FLAGS, 32'h0000_0002, "grp1");
        @(negedge clk_i);
        `CHK("grp_req", 3'h2, grp_req)
        wr(EPC_IDX_GRP_ENABLE, 32'h0000_0000);
        @(negedge clk_i);
        `CHK("grp_off", 3'h0, grp_req)
        wr(EPC_IDX_PC_FLAGS, 32'h0000_0002);
        rc(EPC_IDX_PC_FLAGS, 32'h0000_0000, "grp_w1c");
        // both watched pins fall; the core enters group 1 and its flag clears
        wr(EPC_IDX_GRP_ENABLE, 32'h0000_0002);
        ack_en <= 1;
        pc_in <= 24'h00_0000;
        k = 0;
        while (grp_req[1] !== 1'b1 && k < 20) begin @(negedge clk_i); k++; end
        `CHK("grp_vec", 1'b1, grp_req[1])
        step(8);
        rc(EPC_IDX_PC_FLAGS, 32'h0000_0000, "grp_ack");
        ack_en <= 0;
        $display("test group done");
        // summary interrupt: raise, mask, unmask, clear
        wr(EPC_IDX_IRQ_CLEAR, 32'h0000_07ff);
        rc(EPC_IDX_IRQ_STATUS, 32'h0000_0000, "st_clr");
        wr(EPC_IDX_IRQ_ENABLE, 32'h0000_0008);
        ext_in <= 8'h00;
        step(6);
        ext_in <= 8'h08;
        step(6);
        @(negedge clk_i);
        `CHK("irq_on", 1'b1, irq_o)
        wr(EPC_IDX_IRQ_STATUS, 32'h0000_0000);
        rc(EPC_IDX_IRQ_STATUS, 32'h0000_0008, "st_ro");
        wr(EPC_IDX_IRQ_ENABLE, 32'h0000_0000);
        step(1);
        @(negedge clk_i);
        `CHK("irq_mask", 1'b0, irq_o)
        wr(EPC_IDX_IRQ_ENABLE, 32'h0000_0008);
        step(1);
        @(negedge clk_i);
        `CHK("irq_unmask", 1'b1, irq_o)
        wr(EPC_IDX_IRQ_CLEAR, 32'h0000_0008);
        step(1);
        @(negedge clk_i);
        `CHK("irq_clr", 1'b0, irq_o)
        $display("test irq done");
        // sleeping with inputs disabled drops buffer of high input 2
        wr(EPC_IDX_EXT_ENABLE, 32'h0000_0000);
        ext_in <= 8'h04;
        step(6);
        wr(EPC_IDX_EXT_FLAGS, 32'h0000_00ff);
        sleep <= 1;
        step(6);
        rc(EPC_IDX_EXT_FLAGS, 32'h0000_0004, "sleep");
        $display("test sleep done");
        print_verdict();
    end
endmodule
